//--- src/wcp_top.v
// Watchpoint coupling and trace port gating block.
// Assumes one clock shared as system and JTAG clock, inputs synchronous.
// Function
// - Unit 1 address hit enables chain latch
// - Chain latch captures unit 1 data hit
// - Chain latch drives unit 0 chain input
// - Unit 0 fires on address match when chained
// - Range output is address AND data hit
// - Disabled unit 1 raises range, no breakpoint
// - Unit 0 range-at-zero fires only when range low
// - Sample external debug conditions on clock edge
// - Trace outputs frozen while port enable low
// - One clock for system and JTAG, gated
// - TAP controllers connected in parallel
// - Trace unit programmed via scan chain six
// - Unit 0 triggers only after unit 1 matched when its chain bit is set
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wcp_regs.vh"
module wcp_top #(
  parameter AW = 32,                          // Address width
  parameter DW = 32                           // Data width
) (
  input  wire          i_clk,                 // System and JTAG clock
  input  wire          i_rstn,                // Synchronous reset, active low
  input  wire [3:0]    i_reg_addr,            // Register index
  input  wire [31:0]   i_reg_wdata,           // Register write data
  input  wire          i_reg_wr,              // Write strobe
  input  wire          i_reg_rd,              // Read strobe
  output reg  [31:0]   o_reg_rdata,           // Read data, cycle after strobe
  input  wire [AW-1:0] i_addr,                // Processor address bus
  input  wire [DW-1:0] i_data,                // Processor data bus
  input  wire [4:0]    i_addr_ctl,            // Address-side control bits
  input  wire [1:0]    i_data_ctl,            // Core data-side control bits
  input  wire [1:0]    i_external_debug_condition, // External conditions
  input  wire          i_trace_port_enable,   // Trace port gate
  input  wire          i_jtag_clock_enable,   // Qualifies JTAG activity
  input  wire          i_debug_request,       // Debug request incl. trace unit
  input  wire [AW-1:0] i_trace_addr,          // Trace address source
  input  wire [DW-1:0] i_trace_data,          // Trace data source
  input  wire          i_trace_high_vec,      // High vector state source
  output reg           o_chain_latch_out,     // Chain latch of unit 1
  output reg  [1:0]    o_range_match_out,     // Range outputs of both units
  output reg           o_breakpoint,          // Breakpoint from unit 0 or 1
  output reg           o_debug_request,       // Registered debug request
  output reg  [AW-1:0] o_trace_addr,          // Gated trace address
  output reg  [DW-1:0] o_trace_data,          // Gated trace data
  output reg           o_high_vector_trace_out // Gated high vector state
);
  reg  [AW-1:0] w_av   [0:1];
  reg  [AW-1:0] w_am   [0:1];
  reg  [DW-1:0] w_dv   [0:1];
  reg  [DW-1:0] w_dm   [0:1];
  reg  [`WCP_C_W-1:0] w_ctl [0:1];
  reg  [1:0]    ext_cond;
  reg  [3:0]    scan_chain;
  wire [1:0]    addr_hit;
  wire [1:0]    data_hit;
  wire [2:0]    dctl;
  wire          chain_ok;
  wire          range_ok;
  wire          next_bkpt;

  // Control bit 7 of the data side carries external condition 1
  assign dctl = {ext_cond[1], i_data_ctl};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_unit
      // Unit 1 owns indices 0-4, unit 0 indices 5-9
      localparam [3:0] UBASE = (g == 1) ? 4'h0 : 4'h5;
      wcp_comparator #(.AW(AW), .DW(DW)) u_cmp (
        .i_addr     (i_addr),
        .i_actl     ({i_addr_ctl[4:1], ext_cond[0]}),
        .i_data     (i_data),
        .i_dctl     (dctl),
        .i_av       (w_av[g]),
        .i_am       (w_am[g]),
        .i_acv      (w_ctl[g][`WCP_C_AV_HI:`WCP_C_AV_LO]),
        .i_acm      (w_ctl[g][`WCP_C_AM_HI:`WCP_C_AM_LO]),
        .i_dv       (w_dv[g]),
        .i_dm       (w_dm[g]),
        .i_dcv      (w_ctl[g][`WCP_C_DV_HI:`WCP_C_DV_LO]),
        .i_dcm      (w_ctl[g][`WCP_C_DM_HI:`WCP_C_DM_LO]),
        .o_addr_hit (addr_hit[g]),
        .o_data_hit (data_hit[g])
      );
      always @(posedge i_clk) begin
        if (!i_rstn) begin
          w_av[g]  <= {AW{1'b0}};
          w_am[g]  <= {AW{1'b1}};
          w_dv[g]  <= {DW{1'b0}};
          w_dm[g]  <= {DW{1'b1}};
          w_ctl[g] <= `WCP_CTRL_RST;
        end else if (i_reg_wr) begin
          if (i_reg_addr == `WCP_A_W1_ADDR_VAL + UBASE)
            w_av[g] <= i_reg_wdata[AW-1:0];
          if (i_reg_addr == `WCP_A_W1_ADDR_MASK + UBASE)
            w_am[g] <= i_reg_wdata[AW-1:0];
          if (i_reg_addr == `WCP_A_W1_DATA_VAL + UBASE)
            w_dv[g] <= i_reg_wdata[DW-1:0];
          if (i_reg_addr == `WCP_A_W1_DATA_MASK + UBASE)
            w_dm[g] <= i_reg_wdata[DW-1:0];
          if (i_reg_addr == `WCP_A_W1_CTRL + UBASE)
            w_ctl[g] <= i_reg_wdata[`WCP_C_W-1:0];
        end
      end
    end
  endgenerate

  // Unit 0 qualifiers: chain requirement and range value/mask
  assign chain_ok = !w_ctl[0][`WCP_C_CHAIN] || o_chain_latch_out;
  // Range input taken straight from unit 1 compare, same cycle as unit 0
  assign range_ok = w_ctl[0][`WCP_C_RNGM] ||
                    ((addr_hit[1] & data_hit[1]) == w_ctl[0][`WCP_C_RNGV]);
  // Unit 1 with enable cleared only feeds range and chain, never fires
  assign next_bkpt = (w_ctl[0][`WCP_C_EN] && addr_hit[0] && data_hit[0] &&
                      chain_ok && range_ok) ||
                     (w_ctl[1][`WCP_C_EN] && addr_hit[1] && data_hit[1]);

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      ext_cond          <= 2'h0;
      o_chain_latch_out <= 1'b0;
      o_range_match_out <= 2'h0;
      o_breakpoint      <= 1'b0;
      o_debug_request   <= 1'b0;
      scan_chain        <= 4'h0;
    end else begin
      ext_cond <= i_external_debug_condition;
      if (addr_hit[1])
        o_chain_latch_out <= data_hit[1];
      // Range flop kept as registered output only; unit 0 takes the unregistered compare
      o_range_match_out[1] <= addr_hit[1] & data_hit[1];
      o_range_match_out[0] <= addr_hit[0] & data_hit[0];
      o_breakpoint    <= next_bkpt;
      o_debug_request <= i_debug_request;
      // Scan chain select only moves on qualified JTAG cycles
      if (i_jtag_clock_enable && i_reg_wr && i_reg_addr == `WCP_A_SCAN_CHAIN)
        scan_chain <= i_reg_wdata[3:0];
    end
  end

  // Trace port frozen while enable is low
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_trace_addr            <= {AW{1'b0}};
      o_trace_data            <= {DW{1'b0}};
      o_high_vector_trace_out <= 1'b0;
    end else if (i_trace_port_enable) begin
      o_trace_addr            <= i_trace_addr;
      o_trace_data            <= i_trace_data;
      o_high_vector_trace_out <= i_trace_high_vec;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_reg_rdata <= 32'h0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `WCP_A_W1_ADDR_VAL:  o_reg_rdata <= w_av[1];
        `WCP_A_W1_ADDR_MASK: o_reg_rdata <= w_am[1];
        `WCP_A_W1_DATA_VAL:  o_reg_rdata <= w_dv[1];
        `WCP_A_W1_DATA_MASK: o_reg_rdata <= w_dm[1];
        `WCP_A_W1_CTRL:      o_reg_rdata <= {12'h0, w_ctl[1]};
        `WCP_A_W0_ADDR_VAL:  o_reg_rdata <= w_av[0];
        `WCP_A_W0_ADDR_MASK: o_reg_rdata <= w_am[0];
        `WCP_A_W0_DATA_VAL:  o_reg_rdata <= w_dv[0];
        `WCP_A_W0_DATA_MASK: o_reg_rdata <= w_dm[0];
        `WCP_A_W0_CTRL:      o_reg_rdata <= {12'h0, w_ctl[0]};
        `WCP_A_STATUS:       o_reg_rdata <= {26'h0, ext_cond, o_range_match_out,
                                             o_breakpoint, o_chain_latch_out};
        // Trace unit reached through this chain number
        `WCP_A_SCAN_CHAIN:   o_reg_rdata <= {27'h0, scan_chain == `WCP_TRACE_CHAIN,
                                             scan_chain};
        default:             o_reg_rdata <= 32'h0;
      endcase
    end else begin
      o_reg_rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

//--- src/wcp_regs.vh
// Constants for the watchpoint chain and trace port block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef WCP_REGS_VH
`define WCP_REGS_VH

// Register offsets (word index on the plain register port)
`define WCP_A_W1_ADDR_VAL   4'h0
`define WCP_A_W1_ADDR_MASK  4'h1
`define WCP_A_W1_DATA_VAL   4'h2
`define WCP_A_W1_DATA_MASK  4'h3
`define WCP_A_W1_CTRL       4'h4
`define WCP_A_W0_ADDR_VAL   4'h5
`define WCP_A_W0_ADDR_MASK  4'h6
`define WCP_A_W0_DATA_VAL   4'h7
`define WCP_A_W0_DATA_MASK  4'h8
`define WCP_A_W0_CTRL       4'h9
`define WCP_A_STATUS        4'ha
`define WCP_A_SCAN_CHAIN    4'hb

// Control register: [4:0] addr ctrl value, [7:5] data ctrl value,
// [12:8] addr ctrl mask, [15:13] data ctrl mask, [16] enable,
// [17] chain required, [18] range value, [19] range mask (1 = ignore)
`define WCP_C_AV_LO   0
`define WCP_C_AV_HI   4
`define WCP_C_DV_LO   5
`define WCP_C_DV_HI   7
`define WCP_C_AM_LO   8
`define WCP_C_AM_HI   12
`define WCP_C_DM_LO   13
`define WCP_C_DM_HI   15
`define WCP_C_EN      16
`define WCP_C_CHAIN   17
`define WCP_C_RNGV    18
`define WCP_C_RNGM    19
`define WCP_C_W       20
`define WCP_CTRL_RST  20'h80000

// Scan chain number of the trace unit programming path
`define WCP_TRACE_CHAIN 4'h6

`endif

//--- src/wcp_comparator.v
// One watchpoint comparator: masked address and data match.
// Assumes bus and control values are synchronous to the block clock.
`timescale 1ns/1ps
`default_nettype none
module wcp_comparator #(
  parameter AW = 32,                          // Address width
  parameter DW = 32                           // Data width
) (
  input  wire [AW-1:0] i_addr,                // Current address
  input  wire [4:0]    i_actl,                // Address-side control bits
  input  wire [DW-1:0] i_data,                // Current data
  input  wire [2:0]    i_dctl,                // Data-side control bits
  input  wire [AW-1:0] i_av,                  // Address value
  input  wire [AW-1:0] i_am,                  // Address mask
  input  wire [4:0]    i_acv,                 // Address control value
  input  wire [4:0]    i_acm,                 // Address control mask
  input  wire [DW-1:0] i_dv,                  // Data value
  input  wire [DW-1:0] i_dm,                  // Data mask
  input  wire [2:0]    i_dcv,                 // Data control value
  input  wire [2:0]    i_dcm,                 // Data control mask
  output wire          o_addr_hit,            // Masked address compare
  output wire          o_data_hit             // Masked data compare
);
  // Every bit equal or masked
  assign o_addr_hit = &((~({i_av, i_acv} ^ {i_addr, i_actl})) | {i_am, i_acm});
  assign o_data_hit = &((~({i_dv, i_dcv} ^ {i_data, i_dctl})) | {i_dm, i_dcm});
endmodule
`default_nettype wire

//--- verification/wcp_trace_unit.sv
// Behavioural trace unit model on the far side of the trace port.
// Assumes it shares the processor clock and is reset by the TAP reset.
`timescale 1ns/1ps
`default_nettype none
module wcp_trace_unit (
  input  wire logic i_clk,               // Shared system and test clock
  input  wire logic i_tap_reset_n,       // TAP reset, active low
  input  wire logic i_ctrl_write,        // Control register programmed
  input  wire logic i_session_start,     // Debug session begins
  input  wire logic i_req,               // Request already on the input
  output var  logic o_trace_powered_off, // Unit disabled
  output wire logic o_trace_port_enable, // Gate to the processor
  output wire logic o_debug_request      // Combined debug request
);
  logic own_req;
  // Only the TAP reset clears state, so tracing survives a warm reset
  always @(posedge i_clk) begin
    own_req <= i_tap_reset_n && i_session_start;
    if (!i_tap_reset_n) o_trace_powered_off <= 1'b1;
    else if (i_ctrl_write || i_session_start) o_trace_powered_off <= 1'b0;
  end
  assign o_trace_port_enable = !o_trace_powered_off;
  assign o_debug_request = i_req | own_req;
endmodule
`default_nettype wire

//--- verification/wcp_top_monitor.sv
// Port-level checker for the watchpoint chain and trace port block.
// Assumes status at index a and scan chain select at index b.
`timescale 1ns/1ps
`default_nettype none
module wcp_top_monitor #(parameter AW = 32, parameter DW = 32) (
  input wire logic          i_clk,                      // Clock
  input wire logic          i_rstn,                     // Sync reset
  input wire logic [3:0]    i_reg_addr,                 // Register index
  input wire logic          i_reg_rd,                   // Read strobe
  input wire logic [31:0]   o_reg_rdata,                // Read data
  input wire logic [1:0]    i_external_debug_condition, // Conditions
  input wire logic          i_trace_port_enable,        // Trace gate
  input wire logic          i_debug_request,            // Request in
  input wire logic [AW-1:0] i_trace_addr,               // Trace source
  input wire logic          o_chain_latch_out,          // Chain latch
  input wire logic [1:0]    o_range_match_out,          // Range outputs
  input wire logic          o_breakpoint,               // Breakpoint
  input wire logic          o_debug_request,            // Request out
  input wire logic [AW-1:0] o_trace_addr,               // Gated address
  input wire logic          o_high_vector_trace_out     // Gated vector
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_dbgreq_copy: assert property ($past(i_rstn) |-> o_debug_request == $past(i_debug_request))
    else $error("debug request not copied");
  a_trace_frozen: assert property ($past(i_rstn) && !$past(i_trace_port_enable) |->
    $stable(o_trace_addr) && $stable(o_high_vector_trace_out)) else $error("trace moved");
  a_trace_follow: assert property ($past(i_rstn) && $past(i_trace_port_enable) |->
    o_trace_addr == $past(i_trace_addr)) else $error("trace not updated");
  a_range_chain: assert property (o_range_match_out[1] |-> o_chain_latch_out)
    else $error("range hit without chain");
  a_status_chain: assert property ($past(i_rstn) && $past(i_reg_rd) && $past(i_reg_addr) == 4'ha
    |-> o_reg_rdata[0] == $past(o_chain_latch_out)) else $error("status chain wrong");
  a_ext_sample: assert property ($past(i_rstn, 2) && $past(i_reg_rd) && $past(i_reg_addr) == 4'ha
    |-> o_reg_rdata[5:4] == $past(i_external_debug_condition, 2)) else $error("ext wrong");
  a_scan_flag: assert property ($past(i_rstn) && $past(i_reg_rd) && $past(i_reg_addr) == 4'hb
    |-> o_reg_rdata[4] == (o_reg_rdata[3:0] == 4'h6)) else $error("scan flag wrong");
  a_unmapped_zero: assert property ($past(i_rstn) && $past(i_reg_rd) && $past(i_reg_addr) > 4'hb
    |-> o_reg_rdata == 32'h0) else $error("unmapped read not zero");
  c_chain: cover property (o_chain_latch_out && !o_range_match_out[1]);
  c_bkpt: cover property (o_breakpoint);
  c_gate: cover property (!i_trace_port_enable ##1 i_trace_port_enable);
endmodule
bind wcp_top wcp_top_monitor #(.AW(AW), .DW(DW)) wcp_top_monitor_inst (.*);
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the watchpoint chain and trace port block.
// Assumes the trace unit model drives the port enable and request.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk = 0, i_rstn = 0, i_reg_wr = 0, i_reg_rd = 0, i_jtag_clock_enable = 0;
  logic        i_trace_high_vec = 0, oth_req = 0, session = 0;
  logic [3:0]  i_reg_addr = 0;
  logic [4:0]  i_addr_ctl = 0;
  logic [1:0]  i_data_ctl = 0, i_external_debug_condition = 0;
  logic [31:0] i_reg_wdata = 0, i_addr = 0, i_data = 0, i_trace_addr = 0, i_trace_data = 0;
  logic [31:0] av, dv, b0, a, corner [5] = '{0, 31, 32, 255, 256};
  wire         i_trace_port_enable, i_debug_request, powered_off, o_chain_latch_out;
  wire         o_breakpoint, o_debug_request, o_high_vector_trace_out;
  wire  [1:0]  o_range_match_out;
  wire  [31:0] o_reg_rdata, o_trace_addr, o_trace_data;
  int          fail_count = 0, num_checks = 0, cyc_n = 0;
  wcp_top wcp_top_inst (.*);
  // One dedicated unit, TAP in parallel, high vector source driven by the bench and output checked
  wcp_trace_unit wcp_trace_unit_inst (.i_clk(i_clk), .i_tap_reset_n(i_rstn),
    .i_ctrl_write(i_reg_wr && i_reg_addr == 4'hb && i_jtag_clock_enable),
    .i_session_start(session), .i_req(oth_req), .o_trace_powered_off(powered_off),
    .o_trace_port_enable(i_trace_port_enable), .o_debug_request(i_debug_request));
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge i_clk) {i_reg_addr, i_reg_wdata, i_reg_wr} <= {ad, d, 1'b1};
    @(posedge i_clk) i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge i_clk) {i_reg_addr, i_reg_rd} <= {ad, 1'b1};
    @(posedge i_clk) i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata & msk, exp);
  endtask
  task automatic bus(input logic [31:0] ad, input logic [31:0] d, input int n);
    @(posedge i_clk) {i_addr, i_data} <= {ad, d};
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  function automatic logic exp_bkpt(input logic [31:0] x);
    return x >= 32 && x < 256;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(49));
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk) {i_trace_addr, i_trace_data, i_trace_high_vec} <= {$urandom, $urandom, 1'b1};
    bus(0, 0, 2);
    chk({o_trace_addr, powered_off}, 33'h1);
    session <= 1'b1;
    @(posedge i_clk) session <= 1'b0;
    @(posedge i_clk) #1 chk({o_debug_request, o_high_vector_trace_out, powered_off}, 3'b110);
    chk(o_trace_addr, i_trace_addr);
    chk(o_trace_data, i_trace_data);
    $display("test trace gate done");
    wr(4'hb, 32'h6);
    rd(4'hb, 32'h0, 32'h1f);
    i_jtag_clock_enable <= 1'b1;
    wr(4'hb, 32'h6);
    rd(4'hb, 32'h16, 32'h1f);
    rd(4'hf, 32'h0, 32'hffffffff);
    i_external_debug_condition <= 2'($urandom);
    bus(0, 0, 2);
    rd(4'ha, {26'h0, i_external_debug_condition, 4'h0}, 32'h30);
    $display("test registers done");
    {av, dv} = {$urandom, $urandom};
    b0 = av ^ 32'h100;
    wr(0, av); wr(1, 0); wr(2, dv); wr(3, 0); wr(4, 32'h8ff00);
    wr(5, b0); wr(6, 0); wr(9, 32'hbff00);
    bus(av, ~dv, 1);
    chk(o_chain_latch_out, 0);
    bus(b0, 0, 1);
    chk(o_breakpoint, 0);
    bus(av, dv, 1);
    chk({o_chain_latch_out, o_range_match_out[1], o_breakpoint}, 3'b110);
    bus(b0, 0, 1);
    chk({o_chain_latch_out, o_breakpoint}, 2'b11);
    $display("test chain done");
    wr(0, 0); wr(1, 32'h1f); wr(3, 32'hffffffff); wr(5, 0); wr(6, 32'hff); wr(9, 32'h1ff00);
    for (int k = 0; k < 16; k++) begin
      a = k < 5 ? corner[k] : ($urandom & 32'h1ff);
      oth_req <= 1'($urandom);
      bus(a, $urandom, 3);
      chk({o_breakpoint, o_range_match_out[1]}, {exp_bkpt(a), a < 32});
      chk(o_debug_request, oth_req);
      chk(o_range_match_out[0], a < 256);
    end
    $display("test range done");
    print_verdict();
  end
endmodule
`default_nettype wire
